// ==== ssfs_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Latch interface-select strap at reset release; high=EEPROM
// - Strap high: two-wire pins serve EEPROM master
// - Strap low: two-wire pins serve SMBus slave
// - Port-4 over-current input low means over-current
// - If enabled, select pin shows upstream suspend high
// - Latch power-management strap at reset release
// - Strap low enables power switching; high unsupported
// - SMBus mode: address bit1 from power strap
// - If enabled, power pin shows SuperSpeed connection
module ssfs_top
   import ssfs_pkg::*;
(
   // Clock and reset
   input  wire logic I_CLK,
   input  wire logic I_RST_N,
   // Strap and status pins (input side)
   input  wire logic I_IFSEL_PIN,
   input  wire logic I_FPM_PIN_N,
   input  wire logic I_OC4_N,
   // Strap pins reused as outputs
   output logic      O_IFSEL_PIN,
   output logic      O_IFSEL_PIN_OE,
   output logic      O_FPM_PIN,
   output logic      O_FPM_PIN_OE,
   // Two-wire pins
   input  wire logic I_TW_CLK,
   input  wire logic I_TW_DAT,
   output logic      O_TW_CLK,
   output logic      O_TW_CLK_OE,
   output logic      O_TW_DAT,
   output logic      O_TW_DAT_OE,
   // EEPROM master engine side
   input  wire logic I_EEP_CLK_OE,
   input  wire logic I_EEP_DAT_OE,
   output logic      O_EEP_EN,
   output logic      O_EEP_CLK,
   output logic      O_EEP_DAT,
   // SMBus slave engine side
   input  wire logic I_SMB_CLK_OE,
   input  wire logic I_SMB_DAT_OE,
   output logic      O_SMB_EN,
   output logic      O_SMB_CLK,
   output logic      O_SMB_DAT,
   output logic      O_SMB_ADDR_BIT1,
   // Additional-feature enables and upstream status
   input  wire logic I_SUSP_STATUS_EN,
   input  wire logic I_CONN_STATUS_EN,
   input  wire logic I_SS_SUSPENDED,
   input  wire logic I_SS_CONNECTED,
   // Decoded configuration and events
   output logic      O_EEPROM_MODE,
   output logic      O_PWR_SW_EN,
   output logic      O_OC4_EVENT,
   output logic      O_STRAPS_VALID
);

   ssfs_state_e      state_q;
   ssfs_state_e      state_d;
   logic [2:0]       settle_q;
   ssfs_strap_s      strap_q;
   logic [PIN_COUNT-1:0] raw;
   logic [PIN_COUNT-1:0] lvl;
   ssfs_od_s         eep_od;
   ssfs_od_s         smb_od;
   ssfs_od_s         sel_od;
   logic             run;

   // Raw pins gathered for conditioning
   assign raw[PIN_IFSEL] = I_IFSEL_PIN;
   assign raw[PIN_FPM]   = I_FPM_PIN_N;
   assign raw[PIN_OC4]   = I_OC4_N;
   assign raw[PIN_SCL]   = I_TW_CLK;
   assign raw[PIN_SDA]   = I_TW_DAT;

   ssfs_sync #(
      .WIDTH   (PIN_COUNT)
   ) u_sync (
      .i_clk   (I_CLK),
      .i_rst_n (I_RST_N),
      .i_raw   (raw),
      .o_level (lvl)
   );

   // Sequencer: wait for the conditioner to fill before sampling
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_SETTLE: begin
            if (settle_q == SETTLE_CYCLES) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN:  state_d = ST_RUN; // Only a reset leaves here
         default: state_d = ST_SETTLE;
      endcase
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state_q <= ST_SETTLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Settle counter, counts clock cycles spent in settle
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         settle_q <= SETTLE_ZERO;
      end else if (state_q == ST_SETTLE) begin
         settle_q <= settle_q + SETTLE_STEP;
      end
   end

   assign run = (state_q == ST_RUN);

   // Strap capture: once, on the settle-to-run step; pins not yet
   // driven, so the level seen is the board strap, not our output
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         strap_q.eeprom_mode <= STRAP_IFSEL_RST;
         strap_q.fpm_n       <= STRAP_FPM_RST;
         strap_q.addr_bit1   <= STRAP_FPM_RST;
      end else if (state_q == ST_SETTLE && state_d == ST_RUN) begin
         strap_q.eeprom_mode <= lvl[PIN_IFSEL];
         strap_q.fpm_n       <= lvl[PIN_FPM];
         strap_q.addr_bit1   <= lvl[PIN_FPM];
      end
   end

   // Decoded configuration, stable after capture
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_STRAPS_VALID  <= 1'h0;
         O_EEPROM_MODE   <= 1'h0;
         O_PWR_SW_EN     <= 1'h0;
         O_SMB_ADDR_BIT1 <= 1'h0;
         O_EEP_EN        <= 1'h0;
         O_SMB_EN        <= 1'h0;
      end else begin
         O_STRAPS_VALID  <= run;
         O_EEPROM_MODE   <= run && strap_q.eeprom_mode == IFSEL_EEPROM;
         O_PWR_SW_EN     <= run && strap_q.fpm_n == FPM_SUPPORTED;
         O_SMB_ADDR_BIT1 <= run && strap_q.addr_bit1 &&
                            strap_q.eeprom_mode == IFSEL_SMBUS;
         O_EEP_EN <= run && strap_q.eeprom_mode == IFSEL_EEPROM;
         O_SMB_EN <= run && strap_q.eeprom_mode == IFSEL_SMBUS;
      end
   end

   // Over-current only reported when power switching is supported
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_OC4_EVENT <= 1'h0;
      end else begin
         O_OC4_EVENT <= run && strap_q.fpm_n == FPM_SUPPORTED &&
                        lvl[PIN_OC4] == OC_ACTIVE;
      end
   end

   // Two-wire mux: only the selected engine may pull the wires low
   assign eep_od.clk_oe = I_EEP_CLK_OE;
   assign eep_od.dat_oe = I_EEP_DAT_OE;
   assign smb_od.clk_oe = I_SMB_CLK_OE;
   assign smb_od.dat_oe = I_SMB_DAT_OE;
   always_comb begin
      sel_od = '0;
      if (run && strap_q.eeprom_mode == IFSEL_EEPROM) begin
         sel_od = eep_od;
      end else if (run) begin
         sel_od = smb_od;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_TW_CLK_OE <= 1'h0;
         O_TW_DAT_OE <= 1'h0;
      end else begin
         O_TW_CLK_OE <= sel_od.clk_oe;
         O_TW_DAT_OE <= sel_od.dat_oe;
      end
   end

   // Open drain: value is always low, enable does the work
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_TW_CLK <= OD_LOW;
         O_TW_DAT <= OD_LOW;
      end else begin
         O_TW_CLK <= OD_LOW;
         O_TW_DAT <= OD_LOW;
      end
   end

   // Wire levels to engines; the idle engine sees a quiet bus so a
   // stray pull-down cannot start a false transfer
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_EEP_CLK <= PIN_IDLE;
         O_EEP_DAT <= PIN_IDLE;
         O_SMB_CLK <= PIN_IDLE;
         O_SMB_DAT <= PIN_IDLE;
      end else begin
         O_EEP_CLK <= (run && strap_q.eeprom_mode == IFSEL_EEPROM) ?
                      lvl[PIN_SCL] : PIN_IDLE;
         O_EEP_DAT <= (run && strap_q.eeprom_mode == IFSEL_EEPROM) ?
                      lvl[PIN_SDA] : PIN_IDLE;
         O_SMB_CLK <= (run && strap_q.eeprom_mode == IFSEL_SMBUS) ?
                      lvl[PIN_SCL] : PIN_IDLE;
         O_SMB_DAT <= (run && strap_q.eeprom_mode == IFSEL_SMBUS) ?
                      lvl[PIN_SDA] : PIN_IDLE;
      end
   end

   // Strap pins turned status outputs, only after capture
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_IFSEL_PIN    <= 1'h0;
         O_IFSEL_PIN_OE <= 1'h0;
         O_FPM_PIN      <= 1'h0;
         O_FPM_PIN_OE   <= 1'h0;
      end else begin
         O_IFSEL_PIN_OE <= run && I_SUSP_STATUS_EN;
         O_IFSEL_PIN    <= run && I_SUSP_STATUS_EN && I_SS_SUSPENDED;
         O_FPM_PIN_OE   <= run && I_CONN_STATUS_EN;
         O_FPM_PIN      <= run && I_CONN_STATUS_EN && I_SS_CONNECTED;
      end
   end

endmodule // ssfs_top

`default_nettype wire

// ==== ssfs_pkg.sv ====
`default_nettype none

package ssfs_pkg;

   // Input conditioning
   localparam int unsigned SYNC_STAGES = 3;
   // Filter output shows a pin only after the fourth edge past
   // release, so capture must wait for the fifth
   localparam logic [2:0]  SETTLE_CYCLES = 3'h4;
   localparam logic [2:0]  SETTLE_ZERO   = 3'h0;
   localparam logic [2:0]  SETTLE_STEP   = 3'h1;

   // Strap and pin levels
   localparam logic IFSEL_EEPROM   = 1'h1;
   localparam logic IFSEL_SMBUS    = 1'h0;
   localparam logic FPM_SUPPORTED  = 1'h0;
   localparam logic OC_ACTIVE      = 1'h0;
   localparam logic PIN_IDLE       = 1'h1;
   localparam logic OD_LOW         = 1'h0;

   // Reset values of the latched straps
   localparam logic STRAP_IFSEL_RST = 1'h1;
   localparam logic STRAP_FPM_RST   = 1'h1;

   // Index of each conditioned pin
   localparam int unsigned PIN_IFSEL = 0;
   localparam int unsigned PIN_FPM   = 1;
   localparam int unsigned PIN_OC4   = 2;
   localparam int unsigned PIN_SCL   = 3;
   localparam int unsigned PIN_SDA   = 4;
   localparam int unsigned PIN_COUNT = 5;

   typedef enum logic [1:0] {
      ST_SETTLE = 2'h1,
      ST_RUN    = 2'h2
   } ssfs_state_e;

   // Straps as caught at reset release
   typedef struct packed {
      logic eeprom_mode;
      logic fpm_n;
      logic addr_bit1;
   } ssfs_strap_s;

   // Open-drain drive requests of one two-wire engine
   typedef struct packed {
      logic clk_oe;
      logic dat_oe;
   } ssfs_od_s;

endpackage : ssfs_pkg

`default_nettype wire

// ==== ssfs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssfs_sync
   import ssfs_pkg::*;
#(
   parameter int unsigned WIDTH = PIN_COUNT
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   // Raw pins and filtered levels
   input  wire logic [WIDTH-1:0] i_raw,
   output logic      [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // Three stages; pins idle high through reset (pull-ups)
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
      end else begin
         s1_q <= i_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change counts only once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               o_level[g] <= PIN_IDLE;
            end else if (s2_q[g] == s3_q[g]) begin
               o_level[g] <= s3_q[g];
            end
         end
      end
   endgenerate

endmodule // ssfs_sync

`default_nettype wire

// ==== ssfs_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssfs_checker (
   // Watched ports of the top module
   input wire logic I_CLK, I_RST_N, I_OC4_N, I_EEP_DAT_OE, I_SMB_DAT_OE,
   input wire logic I_SUSP_STATUS_EN, I_CONN_STATUS_EN,
   input wire logic I_SS_SUSPENDED, I_SS_CONNECTED, O_TW_DAT_OE,
   input wire logic O_EEP_EN, O_SMB_EN, O_SMB_ADDR_BIT1, O_EEPROM_MODE,
   input wire logic O_PWR_SW_EN, O_OC4_EVENT, O_STRAPS_VALID,
   input wire logic O_IFSEL_PIN, O_IFSEL_PIN_OE, O_FPM_PIN, O_FPM_PIN_OE
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   // Pin held low long enough to pass the filter
   sequence s_oc_low;
      (!I_OC4_N && O_STRAPS_VALID && O_PWR_SW_EN) [*6];
   endsequence

   property p_mode;
      O_STRAPS_VALID |-> O_EEP_EN == O_EEPROM_MODE && O_SMB_EN != O_EEPROM_MODE;
   endproperty
   a_mode: assert property (p_mode) else $error("engine enables wrong");

   property p_hold;
      O_STRAPS_VALID && $past(O_STRAPS_VALID) |->
         $stable({O_EEPROM_MODE, O_PWR_SW_EN, O_SMB_ADDR_BIT1});
   endproperty
   a_hold: assert property (p_hold) else $error("latched strap moved");

   property p_eep;
      O_STRAPS_VALID && O_EEPROM_MODE |=> O_TW_DAT_OE == $past(I_EEP_DAT_OE);
   endproperty
   a_eep: assert property (p_eep) else $error("eeprom drive lost");

   property p_smb;
      O_STRAPS_VALID && !O_EEPROM_MODE |=> O_TW_DAT_OE == $past(I_SMB_DAT_OE);
   endproperty
   a_smb: assert property (p_smb) else $error("smbus drive lost");

   property p_oc;
      s_oc_low |-> O_OC4_EVENT;
   endproperty
   a_oc: assert property (p_oc) else $error("over-current missed");

   property p_oc_gate;
      O_OC4_EVENT |-> O_PWR_SW_EN;
   endproperty
   a_oc_gate: assert property (p_oc_gate) else $error("event unsupported");

   property p_addr;
      O_STRAPS_VALID |-> O_SMB_ADDR_BIT1 == (!O_EEPROM_MODE && !O_PWR_SW_EN);
   endproperty
   a_addr: assert property (p_addr) else $error("address bit wrong");

   property p_susp;
      O_STRAPS_VALID && I_SUSP_STATUS_EN |=>
         O_IFSEL_PIN_OE && O_IFSEL_PIN == $past(I_SS_SUSPENDED);
   endproperty
   a_susp: assert property (p_susp) else $error("suspend pin wrong");

   property p_conn;
      O_STRAPS_VALID && I_CONN_STATUS_EN |=>
         O_FPM_PIN_OE && O_FPM_PIN == $past(I_SS_CONNECTED);
   endproperty
   a_conn: assert property (p_conn) else $error("connect pin wrong");
endmodule // ssfs_checker

bind ssfs_top ssfs_checker u_chk (.*);

`default_nettype wire

// ==== ssfs_tw_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssfs_tw_partner (
   // Pull-low requests of both sides, resolved wire levels
   input  wire logic i_dut_clk_oe, i_dut_dat_oe, i_pull_clk, i_pull_dat,
   output logic      o_clk, o_dat
);
   // Pull-up wires: any party pulling low wins
   assign o_clk = !(i_dut_clk_oe || i_pull_clk);
   assign o_dat = !(i_dut_dat_oe || i_pull_dat);
endmodule // ssfs_tw_partner

`default_nettype wire

// ==== ssfs_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssfs_top_test
   import ssfs_pkg::*;
;
   // Port-named signals so the instance connects by name
   logic I_CLK = 1'b0, I_RST_N, I_IFSEL_PIN, I_FPM_PIN_N, I_OC4_N;
   logic I_EEP_CLK_OE, I_EEP_DAT_OE, I_SMB_CLK_OE, I_SMB_DAT_OE;
   logic I_SUSP_STATUS_EN, I_CONN_STATUS_EN, I_SS_SUSPENDED, I_SS_CONNECTED;
   logic pull_clk, pull_dat;
   wire  I_TW_CLK, I_TW_DAT, O_IFSEL_PIN, O_IFSEL_PIN_OE, O_FPM_PIN;
   wire  O_FPM_PIN_OE, O_TW_CLK, O_TW_CLK_OE, O_TW_DAT, O_TW_DAT_OE, O_EEP_EN;
   wire  O_EEP_CLK, O_EEP_DAT, O_SMB_EN, O_SMB_CLK, O_SMB_DAT, O_SMB_ADDR_BIT1;
   wire  O_EEPROM_MODE, O_PWR_SW_EN, O_OC4_EVENT, O_STRAPS_VALID;
   int   fail_count = 0, total_checks = 0;

   ssfs_top dut (.*);
   ssfs_tw_partner u_far (.i_dut_clk_oe(O_TW_CLK_OE), .i_dut_dat_oe(O_TW_DAT_OE),
      .i_pull_clk(pull_clk), .i_pull_dat(pull_dat), .o_clk(I_TW_CLK),
      .o_dat(I_TW_DAT));

   // 125 MHz
   always #4 I_CLK = ~I_CLK;

   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Inputs move 1 ns after the edge, clear of sampling
   task automatic step(input int n);
      repeat (n) @(posedge I_CLK);
      #1;
   endtask

   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Every strap combination, each under its own reset
   initial begin
      logic e, f;
      {I_OC4_N, pull_clk, pull_dat} = 3'h4;
      {I_EEP_CLK_OE, I_EEP_DAT_OE, I_SMB_CLK_OE, I_SMB_DAT_OE} = 4'h0;
      {I_SUSP_STATUS_EN, I_CONN_STATUS_EN, I_SS_SUSPENDED, I_SS_CONNECTED} = 4'h0;
      for (int m = 0; m < 4; m++) begin
         e = m[1];
         f = m[0];
         {I_RST_N, I_IFSEL_PIN, I_FPM_PIN_N} = {1'b0, e, f};
         step(8);
         I_RST_N = 1'b1;
         step(8);
         check({O_STRAPS_VALID, O_EEPROM_MODE, O_EEP_EN, O_SMB_EN}, {1'b1, e, e, !e});
         check({2'h0, O_PWR_SW_EN, O_SMB_ADDR_BIT1}, {2'h0, !f, !e && f});
         // Straps flipped after capture must be ignored
         {I_IFSEL_PIN, I_FPM_PIN_N} = {!e, !f};
         step(8);
         check({1'b0, O_EEPROM_MODE, O_PWR_SW_EN, O_SMB_ADDR_BIT1}, {1'b0, e, !f, !e && f});
         {I_EEP_CLK_OE, I_SMB_DAT_OE} = 2'h3;
         step(2);
         check({2'h0, O_TW_CLK_OE, O_TW_DAT_OE}, {2'h0, e, !e});
         step(6);
         check({O_EEP_CLK, O_EEP_DAT, O_SMB_CLK, O_SMB_DAT}, {!e, PIN_IDLE, PIN_IDLE, e});
         {I_EEP_CLK_OE, I_SMB_DAT_OE, pull_dat} = 3'h1;
         step(8);
         check({2'h0, O_EEP_DAT, O_SMB_DAT}, {2'h0, !e, e});
         {pull_dat, I_OC4_N} = 2'h0;
         step(6);
         check({3'h0, O_OC4_EVENT}, {3'h0, !f});
         I_OC4_N = 1'b1;
         step(6);
         check({3'h0, O_OC4_EVENT}, 4'h0);
         {I_SUSP_STATUS_EN, I_CONN_STATUS_EN, I_SS_SUSPENDED, I_SS_CONNECTED} = {2'h3, e, f};
         step(2);
         check({O_IFSEL_PIN_OE, O_IFSEL_PIN, O_FPM_PIN_OE, O_FPM_PIN}, {1'b1, e, 1'b1, f});
         {I_SUSP_STATUS_EN, I_CONN_STATUS_EN} = 2'h0;
         // Opposite pair of requests; wire values stay low
         {I_EEP_CLK_OE, I_EEP_DAT_OE, I_SMB_CLK_OE, I_SMB_DAT_OE} = 4'h6;
         step(2);
         check({O_TW_CLK_OE, O_TW_DAT_OE, O_TW_CLK, O_TW_DAT}, {!e, e, OD_LOW, OD_LOW});
         {I_EEP_DAT_OE, I_SMB_CLK_OE} = 2'h0;
      end
      end_of_test;
   end

   // Whole run needs about 2 us
   initial begin
      #20000;
      fail_count++;
      end_of_test;
   end
endmodule // ssfs_top_test

`default_nettype wire
